// ---- rsu_pkg.sv ----
// shared constants for the serial port with direction control
package rsu_pkg;
	// register offsets (host address bits 2:0)
	localparam logic [2:0] OFS_DATA   = 3'h0;
	localparam logic [2:0] OFS_DIVHI  = 3'h1;
	localparam logic [2:0] OFS_IID    = 3'h2;
	localparam logic [2:0] OFS_FMT    = 3'h3;
	localparam logic [2:0] OFS_OUTCTL = 3'h4;
	localparam logic [2:0] OFS_STAT   = 3'h5;
	// character format fields
	localparam int FMT_LEN_LO  = 0;
	localparam int FMT_STOP    = 2;
	localparam int FMT_PAR_EN  = 3;
	localparam int FMT_PAR_EVN = 4;
	localparam int FMT_PAR_STK = 5;
	localparam int FMT_BREAK   = 6;
	localparam int FMT_DIVSEL  = 7;
	localparam logic [2:0] LEN_BASE = 3'h5;
	// output control fields
	localparam int OC_RTS   = 1;
	localparam int OC_IRQEN = 3;
	// link status fields
	localparam int ST_RXRDY  = 0;
	localparam int ST_OVERRUN = 1;
	localparam int ST_PARERR = 2;
	localparam int ST_FRMERR = 3;
	localparam int ST_BRKDET = 4;
	localparam int ST_THRE   = 5;
	localparam int ST_TEMT   = 6;
	// interrupt identification codes
	localparam logic [7:0] IID_NONE  = 8'h01;
	localparam logic [7:0] IID_LINE  = 8'h06;
	localparam logic [7:0] IID_RXDAT = 8'h04;
	localparam logic [7:0] IID_THRE  = 8'h02;
	// reset values
	localparam logic [7:0]  FMT_RST    = 8'h03;
	localparam logic [7:0]  OUTCTL_RST = 8'h00;
	localparam logic [15:0] DIV_RST    = 16'h000c;
	// bit clock: crystal / (32 * divisor); 16 ticks of the x16 clock per bit
	localparam int XTAL_HZ     = 3686400;
	localparam int CORE_HZ     = 250000000;
	localparam int OVERSAMPLE  = 16;
	localparam int PRESCALE_DIV = 2;
	localparam int TICK_HZ     = XTAL_HZ / PRESCALE_DIV;
	// fixed-point phase step of the x16 tick generator, 32-bit accumulator
	localparam logic [31:0] TICK_STEP =
		32'(((64'd1 << 32) * 64'(TICK_HZ)) / 64'(CORE_HZ));
	// host command/answer latency
	localparam int RD_LATENCY = 1;
endpackage

// ---- rsu_link_if.sv ----
// two-wire shared differential line carrier
`timescale 1ns/1ps
interface rsu_link_if;
	// shared pair as seen by each node: driven level and driver enable
	logic dev_tx;
	logic dev_tx_oe;
	logic far_tx;
	logic far_tx_oe;
	logic line;
	// idle line rests at mark through bias
	assign line = dev_tx_oe ? dev_tx : (far_tx_oe ? far_tx : 1'b1);
	modport dev (output dev_tx, output dev_tx_oe, input line);
	modport far (output far_tx, output far_tx_oe, input line);
endinterface

// ---- rsu_far_node.sv ----
// far node: simple serial node sharing the line, byte in/out user port
`timescale 1ns/1ps
module rsu_far_node #(
	parameter logic [15:0] DIVISOR = rsu_pkg::DIV_RST
) (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// link side
	rsu_link_if.far         link,
	// user transmit
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	// user receive
	output logic            rx_valid,
	output logic [7:0]      rx_data
);
	// a zero divisor would wrap dcnt and give one bit-clock tick per 65536 ticks
	if (DIVISOR == 16'h0000) begin : g_div_check
		$error("divisor must be nonzero");
	end

	typedef struct packed {
		logic [31:0] phase;
		logic [3:0]  tcnt;
		logic [3:0]  tbit;
		logic [8:0]  tsh;
		logic        tbusy;
		logic        txd;
		logic        oe;
		logic [3:0]  rcnt;
		logic [3:0]  rbit;
		logic [7:0]  rsh;
		logic        rbusy;
		logic        rv;
		logic [7:0]  rd;
		logic [15:0] dcnt;
	} rsu_far_t;
	rsu_far_t st_reg, st_next;
	logic tick;

	always_comb begin
		st_next = st_reg;
		st_next.rv = 1'b0;
		{tick, st_next.phase} = {1'b0, st_reg.phase} + {1'b0, rsu_pkg::TICK_STEP};
		if (tick) begin
			if (st_reg.dcnt == DIVISOR - 16'h0001) st_next.dcnt = 16'h0000;
			else st_next.dcnt = st_reg.dcnt + 16'h0001;
		end
		// bit-clock ticks at x16 rate
		if (tick && st_reg.dcnt == 16'h0000) begin
			if (st_reg.tbusy) begin
				st_next.tcnt = st_reg.tcnt + 4'h1;
				if (st_reg.tcnt == 4'hf) begin
					st_next.txd = st_reg.tsh[0];
					st_next.tsh = {1'b1, st_reg.tsh[8:1]};
					st_next.tbit = st_reg.tbit + 4'h1;
					if (st_reg.tbit == 4'h9) begin
						st_next.tbusy = 1'b0;
						st_next.oe = 1'b0;
						st_next.txd = 1'b1;
					end
				end
			end
			if (st_reg.rbusy) begin
				st_next.rcnt = st_reg.rcnt + 4'h1;
				if (st_reg.rcnt == 4'h7) begin
					st_next.rbit = st_reg.rbit + 4'h1;
					if (st_reg.rbit == 4'h0 && link.line) st_next.rbusy = 1'b0;
					else if (st_reg.rbit == 4'h9) begin
						st_next.rbusy = 1'b0;
						st_next.rv = link.line;
						st_next.rd = st_reg.rsh;
					end else if (st_reg.rbit != 4'h0)
						st_next.rsh = {link.line, st_reg.rsh[7:1]};
				end
			end else if (!link.line && !st_reg.oe) begin
				st_next.rbusy = 1'b1;
				st_next.rcnt = 4'h1;
				st_next.rbit = 4'h0;
			end
		end
		if (tx_valid && !st_reg.tbusy) begin
			st_next.tbusy = 1'b1;
			st_next.oe = 1'b1;
			st_next.tsh = {tx_data, 1'b0};
			st_next.tcnt = 4'h0;
			st_next.tbit = 4'h0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.txd <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
	end

	assign link.far_tx = st_reg.txd;
	assign link.far_tx_oe = st_reg.oe;
	assign tx_ready = !st_reg.tbusy;
	assign rx_valid = st_reg.rv;
	assign rx_data = st_reg.rd;
endmodule

// ---- rsu_dev_port.sv ----
// device end: host register port, serial engine and driver direction
`timescale 1ns/1ps
// What this block does
// [R01] format bit 7 maps divisor at 0/1
// [R02] divisor low at 0, high at 1
// [R03] bit rate is crystal over 32*divisor
// [R04] divisor 1 gives 115200, 12 gives 9600
// [R05] format bits 1:0 give length minus 5
// [R06] format bit 2 picks one or two stops
// [R07] format bits 3-6 parity and break, normally zero
// [R08] software clears divisor select after loading
// [R09] format 0x03 means 8N1
// [R10] control bit 1 drives request-to-send direction
// [R11] request-to-send steers the line driver only when auto_dir is low
// [R12] auto mode drives while transmit pending
// [R13] control bit 3 gates interrupt, bit 2 inert
// [R14] reading data pops received character
// [R15] status bit 0 shows data waiting
// [R16] offset 2 names pending interrupt source
// [R17] status bit 5 shows holding register empty
// [R18] software raises direction around transmission
// [R19] software read-modify-writes control register
// [R20] clear-to-send ignored, never blocks transmit
// [R21] address bits select one of six registers; 6 and 7 read zero
// [R22] id bit 0 high means nothing pending
module rsu_dev_port (
	// clock and reset
	input  wire logic       core_clk,
	input  wire logic       srst,
	// host register port
	input  wire logic       bus_sel,
	input  wire logic [2:0] bus_addr,
	input  wire logic       bus_wr,
	input  wire logic       bus_rd,
	input  wire logic [7:0] bus_wdata,
	output logic [7:0]      bus_rdata,
	output logic            irq,
	// direction control
	input  wire logic       auto_dir,
	output logic            rts_out,
	// link side
	rsu_link_if.dev         link
);
	typedef struct packed {
		logic [7:0]  rdata;
		logic        irq;
		logic        rts;
		logic        oe;
		logic        txd;
		logic [15:0] div;
		logic [7:0]  fmt;
		logic [7:0]  octl;
		logic [7:0]  thr;
		logic        thr_full;
		logic [7:0]  rbr;
		logic        rx_rdy;
		logic [4:0]  lerr;
		logic        thre_ack;
		logic [31:0] phase;
		logic [15:0] dcnt;
		logic [3:0]  tcnt;
		logic [3:0]  tbit;
		logic [10:0] tsh;
		logic        tbusy;
		logic [3:0]  rcnt;
		logic [3:0]  rbit;
		logic [8:0]  rsh;
		logic        rpar;
		logic        rbusy;
	} rsu_dev_t;
	rsu_dev_t st_reg, st_next;
	logic       tick, btick;
	logic [3:0] nbits;
	logic       dat_par, par_bit;
	logic [7:0] tx_mask, stat, iid;
	logic       wr, rd, smp, rx_new;
	logic [4:0] lerr_ev;

	always_comb begin
		st_next = st_reg;
		rx_new = 1'b0;
		lerr_ev = 5'h00;
		wr = bus_sel && bus_wr;
		rd = bus_sel && bus_rd;
		nbits = 4'(st_reg.fmt[1:0]) + 4'(rsu_pkg::LEN_BASE); // R05
		tx_mask = 8'hff >> (3'h3 - st_reg.fmt[1:0]);
		dat_par = ^(st_reg.thr & tx_mask);
		par_bit = st_reg.fmt[rsu_pkg::FMT_PAR_STK] ?
			!st_reg.fmt[rsu_pkg::FMT_PAR_EVN] :
			(dat_par ^ !st_reg.fmt[rsu_pkg::FMT_PAR_EVN]); // R07
		smp = link.line;
		stat = {1'b0, !st_reg.tbusy && !st_reg.thr_full, !st_reg.thr_full,
			st_reg.lerr[4:1], st_reg.rx_rdy}; // R15 R17
		// priority: line error, received data, holding empty
		if (st_reg.lerr[4:1] != 4'h0) iid = rsu_pkg::IID_LINE; // R22
		else if (st_reg.rx_rdy) iid = rsu_pkg::IID_RXDAT; // R16
		else if (!st_reg.thr_full && !st_reg.thre_ack) iid = rsu_pkg::IID_THRE;
		else iid = rsu_pkg::IID_NONE; // R22
		// x16 tick: crystal/2, then divisor count
		{tick, st_next.phase} = {1'b0, st_reg.phase}
			+ {1'b0, rsu_pkg::TICK_STEP}; // R03
		btick = 1'b0;
		if (tick) begin
			if (st_reg.dcnt + 16'h0001 >= st_reg.div) begin
				st_next.dcnt = 16'h0000;
				btick = 1'b1; // R04
			end else st_next.dcnt = st_reg.dcnt + 16'h0001;
		end
		// transmitter; clear-to-send plays no part here
		if (btick && st_reg.tbusy) begin // R20
			st_next.tcnt = st_reg.tcnt + 4'h1;
			if (st_reg.tcnt == 4'hf) begin
				st_next.txd = st_reg.tsh[0] && !st_reg.fmt[rsu_pkg::FMT_BREAK];
				st_next.tsh = {1'b1, st_reg.tsh[10:1]};
				st_next.tbit = st_reg.tbit - 4'h1;
				if (st_reg.tbit == 4'h0) begin
					st_next.tbusy = 1'b0;
					st_next.txd = !st_reg.fmt[rsu_pkg::FMT_BREAK];
				end
			end
		end
		if (!st_next.tbusy && st_reg.thr_full
			&& !st_reg.fmt[rsu_pkg::FMT_DIVSEL]) begin // R08
			st_next.tbusy = 1'b1;
			st_next.thr_full = 1'b0;
			st_next.thre_ack = 1'b0;
			st_next.tcnt = 4'h0;
			// frame: start, data, optional parity, stops; tbit counts down
			st_next.tsh = 11'h7ff;
			st_next.tsh[0] = 1'b0;
			st_next.tsh[8:1] = st_reg.thr | ~tx_mask;
			if (st_reg.fmt[rsu_pkg::FMT_PAR_EN])
				st_next.tsh[nbits + 4'h1] = par_bit;
			// start and every stop bit are counted, so the driver holds
			// through the last stop bit before letting go
			st_next.tbit = nbits + 4'(st_reg.fmt[rsu_pkg::FMT_PAR_EN])
				+ 4'(st_reg.fmt[rsu_pkg::FMT_STOP]) + 4'h2; // R06
		end
		// receiver, sampled mid-bit; own echo ignored while driving
		if (btick) begin
			if (st_reg.rbusy) begin
				st_next.rcnt = st_reg.rcnt + 4'h1;
				if (st_reg.rcnt == 4'h7) begin
					st_next.rbit = st_reg.rbit + 4'h1;
					if (st_reg.rbit == 4'h0 && smp) st_next.rbusy = 1'b0;
					else if (st_reg.rbit > 4'h0 && st_reg.rbit <= nbits) begin
						st_next.rsh = {smp, st_reg.rsh[8:1]};
						st_next.rpar = st_reg.rpar ^ smp;
					end else if (st_reg.rbit == nbits + 4'h1
						&& st_reg.fmt[rsu_pkg::FMT_PAR_EN]) begin
						if (smp != (st_reg.fmt[rsu_pkg::FMT_PAR_STK] ?
							!st_reg.fmt[rsu_pkg::FMT_PAR_EVN] :
							(st_reg.rpar ^ !st_reg.fmt[rsu_pkg::FMT_PAR_EVN])))
							lerr_ev[rsu_pkg::ST_PARERR] = 1'b1;
					end else if (st_reg.rbit != 4'h0) begin
						st_next.rbusy = 1'b0;
						if (st_reg.rx_rdy)
							lerr_ev[rsu_pkg::ST_OVERRUN] = 1'b1;
						st_next.rbr = 8'(st_reg.rsh >> (4'h9 - nbits));
						st_next.rx_rdy = 1'b1;
						rx_new = 1'b1;
						if (!smp) lerr_ev[rsu_pkg::ST_FRMERR] = 1'b1;
						if (!smp && st_reg.rsh == 9'h000)
							lerr_ev[rsu_pkg::ST_BRKDET] = 1'b1;
					end
				end
			end else if (!smp && !st_reg.oe) begin
				st_next.rbusy = 1'b1;
				st_next.rcnt = 4'h1;
				st_next.rbit = 4'h0;
				st_next.rpar = 1'b0;
				st_next.rsh = 9'h000;
			end
		end
		// host reads: answer one cycle later; pops give way to a new arrival
		st_next.rdata = 8'h00;
		if (rd) begin
			unique case (bus_addr) // R21
				rsu_pkg::OFS_DATA: begin
					if (st_reg.fmt[rsu_pkg::FMT_DIVSEL])
						st_next.rdata = st_reg.div[7:0]; // R01
					else begin
						st_next.rdata = st_reg.rbr;
						// a character landing in this cycle stays ready
						if (!rx_new) st_next.rx_rdy = 1'b0; // R14
					end
				end
				rsu_pkg::OFS_DIVHI: st_next.rdata =
					st_reg.fmt[rsu_pkg::FMT_DIVSEL] ? st_reg.div[15:8] : 8'h00;
				rsu_pkg::OFS_IID: begin
					st_next.rdata = iid;
					if (iid == rsu_pkg::IID_THRE) st_next.thre_ack = 1'b1;
				end
				rsu_pkg::OFS_FMT: st_next.rdata = st_reg.fmt;
				rsu_pkg::OFS_OUTCTL: st_next.rdata = st_reg.octl;
				rsu_pkg::OFS_STAT: begin
					st_next.rdata = stat;
					st_next.lerr = 5'h00;
				end
				default: st_next.rdata = 8'h00;
			endcase
		end
		if (wr) begin
			unique case (bus_addr) // R21
				rsu_pkg::OFS_DATA: begin
					if (st_reg.fmt[rsu_pkg::FMT_DIVSEL])
						st_next.div[7:0] = bus_wdata; // R02
					else begin
						st_next.thr = bus_wdata;
						st_next.thr_full = 1'b1;
						st_next.thre_ack = 1'b0;
					end
				end
				rsu_pkg::OFS_DIVHI: begin
					if (st_reg.fmt[rsu_pkg::FMT_DIVSEL])
						st_next.div[15:8] = bus_wdata; // R02
				end
				rsu_pkg::OFS_FMT: st_next.fmt = bus_wdata; // R01 R09
				rsu_pkg::OFS_OUTCTL: st_next.octl = bus_wdata; // R19
				default: ;
			endcase
		end
		// error events win over a clearing status read
		st_next.lerr = st_next.lerr | lerr_ev;
		// direction: auto follows pending data, manual follows control bit
		st_next.rts = st_next.octl[rsu_pkg::OC_RTS]; // R10 R11
		st_next.oe = auto_dir ? (st_next.tbusy || st_next.thr_full) // R12
			: st_next.octl[rsu_pkg::OC_RTS]; // R18
		st_next.irq = st_reg.octl[rsu_pkg::OC_IRQEN]
			&& (iid != rsu_pkg::IID_NONE); // R13
	end

	always_ff @(posedge core_clk) begin
		if (srst) begin
			st_reg <= '0;
			st_reg.txd <= 1'b1;
			st_reg.div <= rsu_pkg::DIV_RST;
			st_reg.fmt <= rsu_pkg::FMT_RST;
			st_reg.octl <= rsu_pkg::OUTCTL_RST;
		end else begin
			st_reg <= st_next;
		end
	end

	assign bus_rdata = st_reg.rdata;
	assign irq = st_reg.irq;
	assign rts_out = st_reg.rts;
	assign link.dev_tx = st_reg.txd;
	assign link.dev_tx_oe = st_reg.oe;
endmodule

// ---- rsu_link_assertions.sv ----
// line-level checks between the device end and the far node
`timescale 1ns/1ps
module rsu_link_assertions #(
	parameter int DIVISOR = 1
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// shared line
	input wire logic dev_tx,
	input wire logic dev_tx_oe,
	input wire logic far_tx,
	input wire logic far_tx_oe,
	input wire logic line
);
	localparam int BIT_CYC = rsu_pkg::CORE_HZ /
		(rsu_pkg::TICK_HZ / rsu_pkg::OVERSAMPLE) * DIVISOR;
	localparam int TOL = 3;
	logic        dev_prev;
	logic        far_prev;
	logic        dev_seen;
	logic [31:0] dev_run;
	logic [31:0] far_run;
	// length of the current level on each driver
	always_ff @(posedge core_clk) begin
		dev_prev <= srst | dev_tx;
		far_prev <= srst | far_tx;
		dev_seen <= !srst & (dev_seen | !dev_tx);
		dev_run <= (srst || dev_tx != dev_prev) ? 32'h1 : dev_run + 32'h1;
		far_run <= (srst || far_tx != far_prev) ? 32'h1 : far_run + 32'h1;
	end
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	chk_reset_line_idle: assert property (disable iff (1'b0)
		srst |=> dev_tx && !dev_tx_oe) else $error("line busy after reset");
	chk_dev_start_held: assert property (
		$fell(dev_tx) |-> (dev_tx_oe && !dev_tx)[*8])
		else $error("device start bit not driven");
	chk_dev_bit_len: assert property (
		$rose(dev_tx) && dev_tx_oe |-> dev_run >= BIT_CYC - TOL
		&& (dev_run + TOL) % BIT_CYC <= 2 * TOL)
		else $error("device low run not whole bits");
	chk_dev_low_max: assert property (
		!dev_tx && !dev_prev |-> dev_run <= 9 * BIT_CYC + 3 * TOL)
		else $error("device low run too long");
	chk_dev_stop_len: assert property (
		$fell(dev_tx) && dev_seen |-> dev_run >= BIT_CYC - TOL)
		else $error("device stop bit too short");
	chk_dev_oe_hold: assert property (
		dev_tx_oe && !dev_tx |=> dev_tx_oe)
		else $error("device driver dropped in a low bit");
	chk_far_start_held: assert property (
		$fell(far_tx) |-> (far_tx_oe && !far_tx)[*8])
		else $error("far start bit not driven");
	chk_far_bit_len: assert property (
		$rose(far_tx) && far_tx_oe |-> far_run >= BIT_CYC - TOL
		&& (far_run + TOL) % BIT_CYC <= 2 * TOL)
		else $error("far low run not whole bits");
	cover property ($fell(dev_tx) && dev_tx_oe);
	cover property ($fell(far_tx) && far_tx_oe);
	cover property ($rose(dev_tx_oe));
	cover property (far_tx_oe && !line);
endmodule

// ---- tb_top.sv ----
// bench: device end and far node joined over the shared line
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
	compares++; \
	if ((g) !== (e)) begin \
		error_cnt++; \
		$display("wrong value %s exp %h got %h", n, e, g); \
	end \
end
module tb_top;
	localparam int BIT = 2170;
	logic       core_clk = 1'b0;
	logic       srst     = 1'b1;
	logic       bus_sel  = 1'b0;
	logic       bus_wr   = 1'b0;
	logic       bus_rd   = 1'b0;
	logic       auto_dir = 1'b1;
	logic       f_valid  = 1'b0;
	logic [2:0] bus_addr = 3'h0;
	logic [7:0] bus_wdata = 8'h00;
	logic [7:0] f_data   = 8'h00;
	logic [7:0] bus_rdata;
	logic [7:0] rx_data;
	logic [7:0] d;
	logic [7:0] e_far;
	logic       irq;
	logic       rts_out;
	logic       tx_ready;
	logic       rx_valid;
	int         error_cnt = 0;
	int         compares = 0;
	int         seed = 32'hb81e;
	int         r;
	logic [7:0] exp_far[$];
	logic [7:0] exp_dev[$];
	rsu_link_if link ();
	rsu_dev_port u_rsu_dev_port (.core_clk(core_clk), .srst(srst),
		.bus_sel(bus_sel), .bus_addr(bus_addr), .bus_wr(bus_wr),
		.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.irq(irq), .auto_dir(auto_dir), .rts_out(rts_out), .link(link));
	rsu_far_node #(.DIVISOR(16'h0001)) u_rsu_far_node (.core_clk(core_clk),
		.srst(srst), .link(link), .tx_valid(f_valid), .tx_data(f_data),
		.tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data));
	rsu_link_assertions #(.DIVISOR(1)) u_rsu_link_assertions (
		.core_clk(core_clk), .srst(srst), .dev_tx(link.dev_tx),
		.dev_tx_oe(link.dev_tx_oe), .far_tx(link.far_tx),
		.far_tx_oe(link.far_tx_oe), .line(link.line));
	always #2 core_clk = ~core_clk;
	always @(negedge core_clk)
		if (rx_valid) begin
			e_far = exp_far.pop_front();
			`CHK("far rx byte", e_far, rx_data)
		end
	task automatic acc(input logic w, input logic [2:0] a,
		input logic [7:0] v);
		@(negedge core_clk);
		bus_sel = 1'b1;
		bus_wr = w;
		bus_rd = !w;
		bus_addr = a;
		bus_wdata = v;
		@(negedge core_clk);
		bus_sel = 1'b0;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		d = bus_rdata;
	endtask
	task automatic rchk(input logic [2:0] a, input logic [7:0] e,
		input string n);
		acc(1'b0, a, 8'h00);
		`CHK(n, e, d)
	endtask
	task automatic send(input logic [7:0] m);
		r = $random(seed);
		exp_far.push_back(r[7:0] | m);
		acc(1'b1, 3'h0, r[7:0]);
		repeat (BIT / 2) @(negedge core_clk);
		`CHK("driver on", 1'b1, link.dev_tx_oe)
		for (int i = 0; i < 40000 && exp_far.size() > 0; i++)
			@(negedge core_clk);
		`CHK("far rx left", 0, exp_far.size())
		repeat (BIT + 300) @(negedge core_clk);
		rchk(3'h5, 8'h60, "tx done");
		rchk(3'h2, 8'h02, "id empty");
		rchk(3'h2, 8'h01, "id none");
	endtask
	task automatic stop_test();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial begin
		repeat (100000) @(posedge core_clk);
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge core_clk);
		@(negedge core_clk);
		srst = 1'b0;
		rchk(3'h3, 8'h03, "format");
		rchk(3'h4, 8'h00, "control");
		rchk(3'h5, 8'h60, "status");
		rchk(3'h1, 8'h00, "hidden div");
		rchk(3'h7, 8'h00, "unmapped");
		acc(1'b1, 3'h3, 8'h83);
		r = $random(seed);
		acc(1'b1, 3'h0, r[7:0]);
		acc(1'b1, 3'h1, r[15:8]);
		rchk(3'h0, r[7:0], "div low");
		rchk(3'h1, r[15:8], "div high");
		acc(1'b1, 3'h0, 8'h01);
		acc(1'b1, 3'h1, 8'h00);
		acc(1'b1, 3'h3, 8'h03);
		send(8'h00);
		`CHK("rts idle", 1'b0, rts_out)
		`CHK("auto release", 1'b0, link.dev_tx_oe)
		auto_dir = 1'b0;
		acc(1'b0, 3'h4, 8'h00);
		acc(1'b1, 3'h4, d | 8'h02);
		`CHK("rts on", 1'b1, rts_out)
		acc(1'b1, 3'h3, 8'h06);
		send(8'h80);
		acc(1'b1, 3'h3, 8'h03);
		acc(1'b0, 3'h4, 8'h00);
		acc(1'b1, 3'h4, d & 8'hfd);
		@(negedge core_clk);
		`CHK("rts off", 1'b0, rts_out)
		`CHK("driver off", 1'b0, link.dev_tx_oe)
		acc(1'b1, 3'h4, 8'h04);
		r = $random(seed);
		exp_dev.push_back(r[7:0]);
		for (int i = 0; i < 100 && tx_ready !== 1'b1; i++)
			@(negedge core_clk);
		f_valid = 1'b1;
		f_data = r[7:0];
		@(negedge core_clk);
		f_valid = 1'b0;
		d = 8'h00;
		for (int i = 0; i < 15000 && d[0] !== 1'b1; i++)
			acc(1'b0, 3'h5, 8'h00);
		`CHK("rx ready", 1'b1, d[0])
		`CHK("irq gated", 1'b0, irq)
		acc(1'b1, 3'h4, 8'h08);
		@(negedge core_clk);
		`CHK("irq on", 1'b1, irq)
		rchk(3'h2, 8'h04, "id rx");
		rchk(3'h0, exp_dev.pop_front(), "dev rx");
		rchk(3'h5, 8'h60, "drained");
		rchk(3'h2, 8'h01, "id idle");
		@(negedge core_clk);
		`CHK("irq off", 1'b0, irq)
		stop_test();
	end
endmodule
